// ==== src/tcs_params.svh ====
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// clock and timing
`define TCS_CLK_NS 4
`define TCS_CEIL_CYC(ns) (((ns) + `TCS_CLK_NS - 1) / `TCS_CLK_NS)
`define TCS_CPLL_LOCK_NS 800
`define TCS_CPLL_LOCK_CYC `TCS_CEIL_CYC(`TCS_CPLL_LOCK_NS)
`define TCS_QPLL_LOCK_NS 1000
`define TCS_QPLL_LOCK_CYC `TCS_CEIL_CYC(`TCS_QPLL_LOCK_NS)
`define TCS_ANALOG_RST_NS 400
`define TCS_ANALOG_RST_CYC `TCS_CEIL_CYC(`TCS_ANALOG_RST_NS)
`define TCS_CODING_RST_NS 120
`define TCS_CODING_RST_CYC `TCS_CEIL_CYC(`TCS_CODING_RST_NS)
`define TCS_PHASE_STEP_NS 64
`define TCS_PHASE_STEP_CYC `TCS_CEIL_CYC(`TCS_PHASE_STEP_NS)
`define TCS_CFG_BUSY_NS 100
`define TCS_CFG_BUSY_CYC `TCS_CEIL_CYC(`TCS_CFG_BUSY_NS)

// register byte offsets
`define TCS_REG_STATUS 4'h0
`define TCS_REG_INTCFG 4'h4
`define TCS_REG_SCAN_CTRL 4'h8
`define TCS_REG_SCAN_ERRS 4'hc

// status fields
`define TCS_ST_TX_DONE 0
`define TCS_ST_RX_DONE 1
`define TCS_ST_RX_ANALOG_DONE 2
`define TCS_ST_CPLL_LOCK 3
`define TCS_ST_QPLL_LOCK 4
`define TCS_ST_CFG_BUSY 5
`define TCS_ST_PHASE_ALIGNED 6
`define TCS_ST_LINEAR_EQ 7
`define TCS_ST_SCAN_LO 8
`define TCS_ST_RATE_LO 10
`define TCS_ST_LOOP_LO 13

// internal config word fields
`define TCS_IC_ADDR_LO 0
`define TCS_IC_DATA_LO 16

// scan control fields and reset value
`define TCS_SC_MASK 0
`define TCS_SC_EXPECT 1
`define TCS_SC_RESET 2'h0

// loopback codes
`define TCS_LB_NEAR_PCS 3'h1
`define TCS_LB_NEAR_PMA 3'h2
`define TCS_LB_FAR_PMA 3'h4
`define TCS_LB_FAR_PCS 3'h6

// avalon response codes
`define TCS_RESP_OK 2'h0
`define TCS_RESP_SLVERR 2'h2

`endif

// ==== src/tcs_pkg.sv ====
package tcs_pkg;
	typedef enum logic [2:0] {
		TCS_PH_IDLE = 3'h0,
		TCS_PH_DLY_RST = 3'h1,
		TCS_PH_INIT = 3'h3,
		TCS_PH_ALIGN = 3'h2,
		TCS_PH_DONE = 3'h6
	} tcs_phase_e;

	typedef enum logic [1:0] {
		TCS_SCAN_IDLE = 2'h0,
		TCS_SCAN_ARMED = 2'h1,
		TCS_SCAN_COUNT = 2'h3
	} tcs_scan_e;

	typedef logic [7:0] tcs_cnt_t;
endpackage : tcs_pkg

// ==== src/tcs_lane_ctrl.sv ====
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_params.svh"

module tcs_lane_ctrl #(
	parameter bit EXTRA_PORTS_EN = 1'b1
) (
	input wire logic sys_clk_i, // 250 MHz core and config clock
	input wire logic rst_b_i, // async core reset, active low
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	output logic [1:0] avs_response_o, // always ok, every address hits
	input wire logic [8:0] lane0_cfg_addr_i, // config register address
	input wire logic lane0_cfg_enable_i, // launch access
	input wire logic lane0_cfg_write_i, // 1 write, 0 read
	input wire logic [15:0] lane0_cfg_wdata_i, // config write data
	output logic [15:0] lane0_cfg_rdata_o, // config read data
	output logic lane0_cfg_ready_o, // access done pulse
	output logic lane0_cfg_busy_o, // internal use of config port
	input wire logic lane0_tx_analog_reset_i, // tx analog reset
	input wire logic lane0_tx_coding_reset_i, // tx coding reset
	input wire logic lane0_rx_analog_reset_i, // rx analog reset
	input wire logic lane0_rx_coding_reset_i, // rx coding reset
	output logic lane0_tx_reset_complete_o, // tx ready
	output logic lane0_rx_reset_complete_o, // rx ready
	output logic lane0_rx_analog_reset_complete_o, // rx analog done
	output logic lane0_tx_phase_aligned_o, // phase alignment done
	output logic lane0_tx_phase_init_complete_o, // phase init done
	output logic lane0_tx_delay_reset_complete_o, // delay soft reset done
	output logic lane0_channel_pll_locked_o, // channel pll lock
	output logic quad_pll_locked_o, // quad pll lock
	input wire logic lane0_scan_trigger_i, // eye-scan trigger pulse
	input wire logic lane0_scan_reset_i, // eye-scan reset
	output logic lane0_scan_error_pulse_o, // one-cycle error pulse
	input wire logic [2:0] lane0_rx_rate_select_i, // rx divider, log2
	input wire logic [2:0] lane0_loopback_select_i, // loopback mode
	input wire logic lane0_rx_invert_i, // invert rx
	input wire logic lane0_tx_invert_i, // invert tx
	input wire logic lane0_linear_eq_select_i, // 0 feedback, 1 linear
	input wire logic lane0_equalizer_reset_i, // reset both equalizers
	input wire logic [1:0] lane0_monitor_select_i, // monitor source
	output logic [6:0] lane0_monitor_output_o, // monitor value
	input wire logic lane0_tx_data_i, // tx bit from core
	output logic lane0_tx_serial_o, // serial out
	input wire logic lane0_rx_serial_i, // serial in
	output logic lane0_rx_data_o // recovered rx bit
);
	localparam logic EN = EXTRA_PORTS_EN;

	function automatic logic lb_near(input logic [2:0] sel);
		lb_near = (sel == `TCS_LB_NEAR_PCS) || (sel == `TCS_LB_NEAR_PMA);
	endfunction : lb_near

	function automatic logic lb_far(input logic [2:0] sel);
		lb_far = (sel == `TCS_LB_FAR_PMA) || (sel == `TCS_LB_FAR_PCS);
	endfunction : lb_far

	// pll lock after core reset release
	tcs_pkg::tcs_cnt_t cpll_cnt_q, qpll_cnt_q;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cpll_cnt_q <= 8'h00;
			qpll_cnt_q <= 8'h00;
			lane0_channel_pll_locked_o <= 1'b0;
			quad_pll_locked_o <= 1'b0;
		end else begin
			if (cpll_cnt_q != 8'(`TCS_CPLL_LOCK_CYC))
				cpll_cnt_q <= cpll_cnt_q + 8'h01;
			if (qpll_cnt_q != 8'(`TCS_QPLL_LOCK_CYC))
				qpll_cnt_q <= qpll_cnt_q + 8'h01;
			lane0_channel_pll_locked_o <= EN && (cpll_cnt_q == 8'(`TCS_CPLL_LOCK_CYC));
			quad_pll_locked_o <= EN && (qpll_cnt_q == 8'(`TCS_QPLL_LOCK_CYC));
		end
	end

	// reset sequencers, index 0 tx, 1 rx; analog phase then coding phase
	logic pll_ok;
	logic [1:0] rst_analog, rst_coding, seq_done;
	logic rx_analog_done;
	assign pll_ok = lane0_channel_pll_locked_o && quad_pll_locked_o;
	assign rst_analog = {lane0_rx_analog_reset_i, lane0_tx_analog_reset_i};
	assign rst_coding = {lane0_rx_coding_reset_i, lane0_tx_coding_reset_i};

	for (genvar d = 0; d < 2; d++) begin : g_seq
		tcs_pkg::tcs_cnt_t ana_q, cod_q;
		always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				ana_q <= 8'(`TCS_ANALOG_RST_CYC);
				cod_q <= 8'(`TCS_CODING_RST_CYC);
			end else if (EN && rst_analog[d]) begin
				ana_q <= 8'(`TCS_ANALOG_RST_CYC);
				cod_q <= 8'(`TCS_CODING_RST_CYC);
			end else if (EN && rst_coding[d]) begin
				cod_q <= 8'(`TCS_CODING_RST_CYC);
			end else if (pll_ok) begin
				if (ana_q != 8'h00)
					ana_q <= ana_q - 8'h01;
				else if (cod_q != 8'h00)
					cod_q <= cod_q - 8'h01;
			end
		end
		assign seq_done[d] = pll_ok && (ana_q == 8'h00) && (cod_q == 8'h00)
			&& !rst_analog[d] && !rst_coding[d];
		if (d == 1) begin : g_rx_ana
			assign rx_analog_done = pll_ok && (ana_q == 8'h00) && !rst_analog[d];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lane0_tx_reset_complete_o <= 1'b0;
			lane0_rx_reset_complete_o <= 1'b0;
			lane0_rx_analog_reset_complete_o <= 1'b0;
		end else begin
			lane0_tx_reset_complete_o <= EN && seq_done[0];
			lane0_rx_reset_complete_o <= EN && seq_done[1];
			lane0_rx_analog_reset_complete_o <= EN && rx_analog_done;
		end
	end

	// tx phase alignment, restarted whenever the tx side leaves ready
	tcs_pkg::tcs_phase_e ph_q;
	tcs_pkg::tcs_cnt_t ph_cnt_q;
	logic ph_step;
	assign ph_step = (ph_cnt_q == 8'(`TCS_PHASE_STEP_CYC - 1));
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ph_q <= tcs_pkg::TCS_PH_IDLE;
			ph_cnt_q <= 8'h00;
		end else if (!lane0_tx_reset_complete_o) begin
			ph_q <= tcs_pkg::TCS_PH_IDLE;
			ph_cnt_q <= 8'h00;
		end else begin
			ph_cnt_q <= (ph_step || ph_q == tcs_pkg::TCS_PH_DONE) ? 8'h00 : ph_cnt_q + 8'h01;
			unique case (ph_q)
				tcs_pkg::TCS_PH_IDLE: ph_q <= tcs_pkg::TCS_PH_DLY_RST;
				tcs_pkg::TCS_PH_DLY_RST: if (ph_step) ph_q <= tcs_pkg::TCS_PH_INIT;
				tcs_pkg::TCS_PH_INIT: if (ph_step) ph_q <= tcs_pkg::TCS_PH_ALIGN;
				tcs_pkg::TCS_PH_ALIGN: if (ph_step) ph_q <= tcs_pkg::TCS_PH_DONE;
				tcs_pkg::TCS_PH_DONE: ph_q <= tcs_pkg::TCS_PH_DONE;
				default: ph_q <= tcs_pkg::TCS_PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lane0_tx_delay_reset_complete_o <= 1'b0;
			lane0_tx_phase_init_complete_o <= 1'b0;
			lane0_tx_phase_aligned_o <= 1'b0;
		end else begin
			lane0_tx_delay_reset_complete_o <= EN && (ph_q == tcs_pkg::TCS_PH_INIT
				|| ph_q == tcs_pkg::TCS_PH_ALIGN || ph_q == tcs_pkg::TCS_PH_DONE);
			lane0_tx_phase_init_complete_o <= EN && (ph_q == tcs_pkg::TCS_PH_ALIGN
				|| ph_q == tcs_pkg::TCS_PH_DONE);
			lane0_tx_phase_aligned_o <= EN && (ph_q == tcs_pkg::TCS_PH_DONE);
		end
	end

	// serial datapath
	logic [6:0] div_q;
	logic rx_strobe, tx_bit, rx_src;
	assign rx_strobe = (div_q == 7'((8'h01 << lane0_rx_rate_select_i) - 8'h01));
	assign tx_bit = lane0_tx_data_i ^ lane0_tx_invert_i;
	assign rx_src = lb_near(lane0_loopback_select_i) ? tx_bit : lane0_rx_serial_i;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= 7'h00;
			lane0_rx_data_o <= 1'b0;
			lane0_tx_serial_o <= 1'b0;
		end else begin
			div_q <= rx_strobe ? 7'h00 : div_q + 7'h01;
			if (rx_strobe && lane0_rx_reset_complete_o)
				lane0_rx_data_o <= rx_src ^ lane0_rx_invert_i;
			if (!lane0_tx_reset_complete_o)
				lane0_tx_serial_o <= 1'b0;
			else if (lb_far(lane0_loopback_select_i))
				lane0_tx_serial_o <= lane0_rx_serial_i;
			else
				lane0_tx_serial_o <= tx_bit;
		end
	end

	// equalizer adaptation: only the selected path adapts
	logic [6:0] lpm_q, dfe_q;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lpm_q <= 7'h00;
			dfe_q <= 7'h00;
		end else if (lane0_equalizer_reset_i) begin
			lpm_q <= 7'h00;
			dfe_q <= 7'h00;
		end else if (rx_strobe && lane0_rx_reset_complete_o) begin
			if (lane0_linear_eq_select_i && lpm_q != 7'h7f)
				lpm_q <= lpm_q + 7'h01;
			if (!lane0_linear_eq_select_i && dfe_q != 7'h7f)
				dfe_q <= dfe_q + 7'h01;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lane0_monitor_output_o <= 7'h00;
		end else if (!EN) begin
			lane0_monitor_output_o <= 7'h00;
		end else begin
			unique case (lane0_monitor_select_i)
				2'h0: lane0_monitor_output_o <= 7'h00;
				2'h1: lane0_monitor_output_o <= lpm_q;
				2'h2: lane0_monitor_output_o <= dfe_q;
				2'h3: lane0_monitor_output_o <= lane0_linear_eq_select_i ? lpm_q : dfe_q;
			endcase
		end
	end

	// eye scan
	tcs_pkg::tcs_scan_e scan_q;
	logic [1:0] scan_ctrl_q;
	logic [15:0] scan_errs_q;
	logic scan_err;
	assign scan_err = EN && rx_strobe && lane0_rx_reset_complete_o
		&& (scan_q != tcs_pkg::TCS_SCAN_IDLE) && !scan_ctrl_q[`TCS_SC_MASK]
		&& ((rx_src ^ lane0_rx_invert_i) != scan_ctrl_q[`TCS_SC_EXPECT]);
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scan_q <= tcs_pkg::TCS_SCAN_IDLE;
		end else if (lane0_scan_reset_i) begin
			scan_q <= tcs_pkg::TCS_SCAN_IDLE;
		end else if (EN && lane0_scan_trigger_i) begin
			unique case (scan_q)
				tcs_pkg::TCS_SCAN_IDLE: scan_q <= tcs_pkg::TCS_SCAN_ARMED;
				tcs_pkg::TCS_SCAN_ARMED: scan_q <= tcs_pkg::TCS_SCAN_COUNT;
				tcs_pkg::TCS_SCAN_COUNT: scan_q <= tcs_pkg::TCS_SCAN_IDLE;
				default: scan_q <= tcs_pkg::TCS_SCAN_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			lane0_scan_error_pulse_o <= 1'b0;
		else
			lane0_scan_error_pulse_o <= scan_err;
	end

	// configuration port and its register space
	logic [15:0] cfg_mem [512];
	logic [15:0] busy_cnt_q;
	logic [31:0] intcfg_q;
	logic int_start, user_acc;
	logic av_req, av_hit, av_wr;
	assign av_req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
	assign av_wr = avs_write_i && !avs_waitrequest_o;
	assign av_hit = (avs_address_i[3:2] <= 2'h3);
	// internal use wins a same-cycle collision; the user access is then dropped
	assign int_start = EN && av_wr && avs_address_i == `TCS_REG_INTCFG && !lane0_cfg_busy_o;
	assign user_acc = EN && lane0_cfg_enable_i && !lane0_cfg_busy_o && !int_start;

	always_ff @(posedge sys_clk_i) begin
		if (int_start)
			cfg_mem[avs_writedata_i[`TCS_IC_ADDR_LO +: 9]] <= avs_writedata_i[`TCS_IC_DATA_LO +: 16];
		else if (user_acc && lane0_cfg_write_i)
			cfg_mem[lane0_cfg_addr_i] <= lane0_cfg_wdata_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lane0_cfg_rdata_o <= 16'h0000;
			lane0_cfg_ready_o <= 1'b0;
		end else begin
			lane0_cfg_ready_o <= user_acc;
			if (user_acc && !lane0_cfg_write_i)
				lane0_cfg_rdata_o <= cfg_mem[lane0_cfg_addr_i];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt_q <= 16'h0000;
			lane0_cfg_busy_o <= 1'b0;
		end else if (int_start) begin
			busy_cnt_q <= 16'(`TCS_CFG_BUSY_CYC - 1);
			lane0_cfg_busy_o <= 1'b1;
		end else if (busy_cnt_q != 16'h0000) begin
			busy_cnt_q <= busy_cnt_q - 16'h0001;
		end else begin
			lane0_cfg_busy_o <= 1'b0;
		end
	end

	// avalon slave: one wait cycle, then the answer
	logic [31:0] status;
	assign status = {16'h0000, lane0_loopback_select_i, lane0_rx_rate_select_i, scan_q,
		lane0_linear_eq_select_i, lane0_tx_phase_aligned_o, lane0_cfg_busy_o,
		quad_pll_locked_o, lane0_channel_pll_locked_o, lane0_rx_analog_reset_complete_o,
		lane0_rx_reset_complete_o, lane0_tx_reset_complete_o};

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
			avs_response_o <= `TCS_RESP_OK;
		end else begin
			avs_waitrequest_o <= !av_req;
			if (av_req) begin
				avs_response_o <= av_hit ? `TCS_RESP_OK : `TCS_RESP_SLVERR;
				unique case ({avs_address_i[3:2], 2'h0})
					`TCS_REG_STATUS: avs_readdata_o <= status;
					`TCS_REG_INTCFG: avs_readdata_o <= intcfg_q;
					`TCS_REG_SCAN_CTRL: avs_readdata_o <= {30'h0, scan_ctrl_q};
					`TCS_REG_SCAN_ERRS: avs_readdata_o <= {16'h0000, scan_errs_q};
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			intcfg_q <= 32'h0000_0000;
			scan_ctrl_q <= `TCS_SC_RESET;
		end else if (av_wr) begin
			if (int_start)
				intcfg_q <= avs_writedata_i;
			if (avs_address_i == `TCS_REG_SCAN_CTRL && avs_byteenable_i[0])
				scan_ctrl_q <= avs_writedata_i[1:0];
		end
	end

	// error count: an error in the clearing cycle is kept, unless the count already sits at 16'hffff
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			scan_errs_q <= 16'h0000;
		else if (scan_err && scan_errs_q != 16'hffff)
			scan_errs_q <= (av_wr && avs_address_i == `TCS_REG_SCAN_ERRS) ? 16'h0001
				: scan_errs_q + 16'h0001;
		else if (av_wr && avs_address_i == `TCS_REG_SCAN_ERRS)
			scan_errs_q <= 16'h0000;
	end

endmodule : tcs_lane_ctrl

`default_nettype wire

// ==== verif/tcs_lane_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_lane_checker (
	input wire logic sys_clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic [3:0] avs_address_i, // addr
	input wire logic avs_read_i, // rd
	input wire logic avs_write_i, // wr
	input wire logic avs_waitrequest_o, // stall
	input wire logic lane0_cfg_enable_i, // launch
	input wire logic lane0_cfg_ready_o, // done
	input wire logic lane0_cfg_busy_o, // busy
	input wire logic lane0_tx_analog_reset_i, // tx rst
	input wire logic lane0_tx_reset_complete_o, // tx up
	input wire logic lane0_rx_reset_complete_o, // rx up
	input wire logic lane0_channel_pll_locked_o, // lock
	input wire logic quad_pll_locked_o, // lock
	input wire logic [2:0] lane0_loopback_select_i, // loop
	input wire logic lane0_tx_data_i, // tx bit
	input wire logic lane0_tx_invert_i, // inv
	input wire logic lane0_tx_serial_o, // serial
	input wire logic [1:0] lane0_monitor_select_i, // sel
	input wire logic [6:0] lane0_monitor_output_o, // mon
	input wire logic lane0_scan_error_pulse_o // err
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// a user access colliding with an internal write is dropped
	wire logic icfg_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
	logic [1:0] lb_idle_q;
	// loopback select may be resynchronised, so let it settle first
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			lb_idle_q <= 2'h0;
		else if (lane0_loopback_select_i != 3'h0)
			lb_idle_q <= 2'h0;
		else if (lb_idle_q != 2'h3)
			lb_idle_q <= lb_idle_q + 2'h1;
	end
	sequence busy_hold;
		lane0_cfg_busy_o [*8];
	endsequence
	cfg_ready_a: assert property (lane0_cfg_enable_i && !lane0_cfg_busy_o && !icfg_wr |=>
		lane0_cfg_ready_o) else $error("config access without ready");
	ready_cause_a: assert property (lane0_cfg_ready_o |-> $past(lane0_cfg_enable_i))
		else $error("ready without access");
	busy_refuse_a: assert property (lane0_cfg_enable_i && lane0_cfg_busy_o |=>
		!lane0_cfg_ready_o) else $error("access served while busy");
	busy_span_a: assert property (icfg_wr && !lane0_cfg_busy_o |=>
		busy_hold ##1 busy_hold ##1 busy_hold ##1 lane0_cfg_busy_o ##1 !lane0_cfg_busy_o)
		else $error("busy span wrong");
	avs_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o) else $error("bus request not answered");
	tx_invert_a: assert property (lb_idle_q == 2'h3 |-> lane0_tx_serial_o ==
		($past(lane0_tx_data_i) ^ $past(lane0_tx_invert_i))) else $error("tx polarity wrong");
	reset_drop_a: assert property (lane0_tx_analog_reset_i |-> ##[1:3]
		!lane0_tx_reset_complete_o) else $error("tx reset not started");
	lock_first_a: assert property (lane0_tx_reset_complete_o |->
		lane0_channel_pll_locked_o && quad_pll_locked_o) else $error("done without lock");
	monitor_zero_a: assert property (lane0_monitor_select_i == 2'h0 [*3] |->
		lane0_monitor_output_o == 7'h0) else $error("monitor not zero");
	scan_gate_a: assert property (lane0_scan_error_pulse_o |->
		$past(lane0_rx_reset_complete_o)) else $error("scan error before rx ready");
endmodule : tcs_lane_checker
`default_nettype wire

// ==== verif/tcs_user_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcs_user_model (
	input wire logic clk_i, // core clock
	input wire logic [15:0] rdata_i, // read data
	input wire logic ready_i, // done
	input wire logic busy_i, // internal use
	output logic [8:0] addr_o, // address
	output logic en_o, // launch
	output logic write_o, // direction
	output logic [15:0] wdata_o // write data
);
	initial {en_o, write_o, addr_o, wdata_o} = '0;
	// chk_busy low lets a scenario collide with internal use on purpose
	task automatic access(input logic wr, input logic [8:0] a, input logic [15:0] d,
		input logic chk_busy, output logic [15:0] rd, output logic got);
		int n;
		got = 1'b0;
		rd = 16'h0;
		for (n = 0; chk_busy && busy_i !== 1'b0 && n < 200; n++)
			@(posedge clk_i);
		@(posedge clk_i);
		en_o <= 1'b1;
		write_o <= wr;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		en_o <= 1'b0;
		// released bus shows garbage, not the last value
		addr_o <= ~a;
		wdata_o <= ~d;
		for (n = 0; n < 8 && !got; n++) begin
			@(posedge clk_i);
			if (ready_i === 1'b1) begin
				got = 1'b1;
				rd = rdata_i;
			end
		end
	endtask : access
endmodule : tcs_user_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, got;
	logic [3:0] avs_address_i, avs_byteenable_i, lrst;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [1:0] avs_response_o, lane0_monitor_select_i;
	logic [8:0] lane0_cfg_addr_i;
	logic [15:0] lane0_cfg_wdata_i, lane0_cfg_rdata_o, crd;
	logic lane0_cfg_enable_i, lane0_cfg_write_i, lane0_cfg_ready_o, lane0_cfg_busy_o;
	logic lane0_tx_analog_reset_i, lane0_tx_coding_reset_i;
	logic lane0_rx_analog_reset_i, lane0_rx_coding_reset_i, lane0_rx_analog_reset_complete_o;
	logic lane0_tx_reset_complete_o, lane0_rx_reset_complete_o, lane0_tx_phase_aligned_o;
	logic lane0_tx_phase_init_complete_o, lane0_tx_delay_reset_complete_o;
	logic lane0_channel_pll_locked_o, quad_pll_locked_o;
	logic lane0_scan_trigger_i, lane0_scan_reset_i, lane0_scan_error_pulse_o;
	logic [2:0] lane0_rx_rate_select_i, lane0_loopback_select_i;
	logic lane0_rx_invert_i, lane0_tx_invert_i, lane0_linear_eq_select_i;
	logic lane0_equalizer_reset_i, lane0_tx_data_i, lane0_tx_serial_o;
	logic lane0_rx_serial_i, lane0_rx_data_o;
	logic [6:0] lane0_monitor_output_o;
	logic [8:0] ca [2] = '{9'h000, 9'h1ff};
	logic [15:0] cd [2] = '{16'ha5c3, 16'h3c5a};
	logic [2:0] lb [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h5};
	int num_errors = 0;
	int compares = 0;
	logic [1:0] aligned_sync_q;
	// phase aligned is a flop on sys_clk_i in the DUT; it is still brought in through two flops
	always_ff @(posedge sys_clk_i) begin
		aligned_sync_q <= {aligned_sync_q[0], lane0_tx_phase_aligned_o};
	end
	assign {lane0_rx_coding_reset_i, lane0_rx_analog_reset_i, lane0_tx_coding_reset_i,
		lane0_tx_analog_reset_i} = lrst;
	tcs_lane_ctrl #(.EXTRA_PORTS_EN(1'b1)) DUT (.*);
	tcs_user_model u_user (.clk_i(sys_clk_i), .rdata_i(lane0_cfg_rdata_o),
		.ready_i(lane0_cfg_ready_o), .busy_i(lane0_cfg_busy_o), .addr_o(lane0_cfg_addr_i),
		.en_o(lane0_cfg_enable_i), .write_o(lane0_cfg_write_i), .wdata_o(lane0_cfg_wdata_i));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask : tick
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk_i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= a;
		avs_writedata_i <= wd;
		for (n = 0; n == 0 || (avs_waitrequest_o !== 1'b0 && n < 50); n++)
			@(posedge sys_clk_i);
		rd = avs_readdata_o;
		chk(n < 50, 1'b1);
		chk(avs_response_o, 2'h0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task automatic settle();
		int n;
		for (n = 0; {lane0_tx_reset_complete_o, lane0_rx_reset_complete_o,
			aligned_sync_q[1]} !== 3'h7 && n < 2000; n++)
			tick(1);
		chk(n < 2000, 1'b1);
	endtask : settle
	task automatic trig();
		lane0_scan_trigger_i <= 1'b1;
		tick(1);
		lane0_scan_trigger_i <= 1'b0;
		tick(3);
	endtask : trig
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// whole sequence needs well under 20 us
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
	initial begin
		{rst_b_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, lrst} = '0;
		{lane0_scan_trigger_i, lane0_scan_reset_i, lane0_rx_rate_select_i} = '0;
		{lane0_loopback_select_i, lane0_rx_invert_i, lane0_tx_invert_i, lane0_tx_data_i} = '0;
		{lane0_linear_eq_select_i, lane0_equalizer_reset_i, lane0_monitor_select_i} = '0;
		lane0_rx_serial_i = 1'b0;
		avs_byteenable_i = 4'hf;
		tick(4);
		rst_b_i <= 1'b1;
		settle();
		bus(1'b0, 4'h0, 32'h0);
		chk(rd[5:0], 6'h1f);
		chk({lane0_tx_phase_init_complete_o, lane0_tx_delay_reset_complete_o}, 2'h3);
		foreach (ca[i]) begin
			u_user.access(1'b1, ca[i], cd[i], 1'b1, crd, got);
			chk(got, 1'b1);
			u_user.access(1'b0, ca[i], 16'h0, 1'b1, crd, got);
			chk(crd, cd[i]);
		end
		bus(1'b1, 4'h4, {16'h1234, 7'h0, 9'h055});
		tick(2);
		chk(lane0_cfg_busy_o, 1'b1);
		u_user.access(1'b0, 9'h055, 16'h0, 1'b0, crd, got);
		chk(got, 1'b0);
		u_user.access(1'b0, 9'h055, 16'h0, 1'b1, crd, got);
		chk(crd, 16'h1234);
		for (int i = 0; i < 4; i++) begin
			lrst <= 4'h1 << i;
			tick(3);
			chk({lane0_rx_reset_complete_o, lane0_tx_reset_complete_o}, i < 2 ? 2 : 1);
			if (i == 2)
				chk(lane0_rx_analog_reset_complete_o, 1'b0);
			lrst <= 4'h0;
			settle();
		end
		foreach (lb[i]) begin
			lane0_loopback_select_i <= lb[i];
			for (int b = 0; b < 2; b++) begin
				lane0_tx_data_i <= b[0];
				lane0_rx_serial_i <= !b[0];
				tick(4);
				if (lb[i] == 3'h1 || lb[i] == 3'h2)
					chk(lane0_rx_data_o, b[0]);
				else if (lb[i] == 3'h4 || lb[i] == 3'h6)
					chk(lane0_tx_serial_o, !b[0]);
				else
					chk({lane0_tx_serial_o, lane0_rx_data_o}, {b[0], !b[0]});
			end
		end
		lane0_loopback_select_i <= 3'h0;
		{lane0_tx_invert_i, lane0_rx_invert_i, lane0_tx_data_i, lane0_rx_serial_i} <= 4'he;
		tick(4);
		chk({lane0_tx_serial_o, lane0_rx_data_o}, 2'h1);
		{lane0_tx_invert_i, lane0_rx_invert_i, lane0_linear_eq_select_i} <= 3'h1;
		lane0_equalizer_reset_i <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			lane0_monitor_select_i <= m[1:0];
			tick(4);
			chk(lane0_monitor_output_o, 7'h0);
		end
		lane0_equalizer_reset_i <= 1'b0;
		tick(20);
		chk(lane0_monitor_output_o, 7'h0);
		lane0_monitor_select_i <= 2'h1;
		tick(4);
		chk(lane0_monitor_output_o != 7'h0, 1'b1);
		lane0_monitor_select_i <= 2'h3;
		tick(130);
		chk(lane0_monitor_output_o, 7'h7f);
		lane0_monitor_select_i <= 2'h0;
		lane0_rx_serial_i <= 1'b0;
		bus(1'b1, 4'h8, 32'h2);
		bus(1'b1, 4'hc, 32'h0);
		trig();
		bus(1'b0, 4'h0, 32'h0);
		chk(rd[9:7], 3'h3);
		bus(1'b0, 4'hc, 32'h0);
		chk(rd != 32'h0, 1'b1);
		bus(1'b1, 4'h8, 32'h3);
		bus(1'b1, 4'hc, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		trig();
		bus(1'b0, 4'h0, 32'h0);
		chk(rd[9:8], 2'h3);
		lane0_scan_reset_i <= 1'b1;
		tick(1);
		lane0_scan_reset_i <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		chk(rd[15:8], 8'h0);
		summarize();
	end
endmodule : tb_top
bind tcs_lane_ctrl tcs_lane_checker u_chk (.*);
`default_nettype wire
